// ### hw/cmm_mem_map.sv
// How it works
// - stop bit write enters stop, reads zero
// - idle bit halts cpu after instruction
// - enabled interrupt clears idle, cpu resumes
// - only reset leaves stop, restart at zero
// - separate 64 kB program space by instruction
// - 8 kB flash, above 0x1DFF reserved
// - 4 kB and 2 kB flash limits
// - program writes only with store enable set
// - 256 bytes of internal data ram
// - lower half direct and indirect reachable
// - 0x00-0x1F are four register banks
// - status bits 3,4 pick active bank
// - 0x20-0x2F bytes or 128 direct bits
// - upper half indirect only, not sfr
// - direct above 0x7F goes to sfrs
// - indirect above 0x7F goes upper ram
// - indirect address from bank reg 0/1
`timescale 1ns/1ps
module cmm_mem_map import cmm_pkg::*; #(
    parameter int FLASH_KB = 8
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    // data access from the core
    input wire logic I_DATA_REQ,
    input wire logic I_DATA_WE,
    input wire logic [1:0] I_DATA_MODE,
    input wire logic [7:0] I_DATA_ADDR,
    input wire logic [2:0] I_REG_IDX,
    input wire logic [7:0] I_DATA_WDATA,
    input wire logic [7:0] I_PROGRAM_STATUS_WORD,
    output logic O_DATA_ACK,
    output logic [7:0] O_DATA_RDATA,
    // external sfr space
    output logic O_SFR_REQ,
    output logic O_SFR_WE,
    output logic O_SFR_BIT,
    output logic [2:0] O_SFR_BIT_IDX,
    output logic [7:0] O_SFR_ADDR,
    output logic [7:0] O_SFR_WDATA,
    input wire logic [7:0] I_SFR_RDATA,
    // program space access
    input wire logic I_PROG_REQ,
    input wire logic I_PROG_WE,
    input wire logic [15:0] I_PROG_ADDR,
    input wire logic [7:0] I_PROG_WDATA,
    output logic O_PROG_ACK,
    output logic O_PROG_RESERVED,
    output logic [7:0] O_PROG_RDATA,
    // power management
    input wire logic I_INSTR_DONE,
    input wire logic I_IRQ_WAKE,
    output logic O_CPU_HALT,
    output logic O_IDLE,
    output logic O_STOP,
    output logic [15:0] O_RESET_PC
);
    localparam logic [15:0] FLASH_TOP = (FLASH_KB == 8) ? FLASH_8K_TOP :
                                        (FLASH_KB == 4) ? FLASH_4K_TOP : FLASH_2K_TOP;
    localparam logic [15:0] USABLE_TOP = (FLASH_KB == 8) ? FLASH_8K_USABLE_TOP : FLASH_TOP;

    // only the three flash sizes have a map; refuse anything else at elaboration
    if (FLASH_KB != 8 && FLASH_KB != 4 && FLASH_KB != 2) begin : g_bad_flash_kb
        $error("FLASH_KB must be 2, 4 or 8");
    end

    cmm_mem_if mem ();
    logic rst_meta;
    logic rst_n;
    cmm_pwr_t pwr_state;
    logic store_we;
    cmm_mode_t mode;
    logic [1:0] bank;
    logic [7:0] eff_addr;
    logic to_sfr;
    logic power_mode_control_hit;
    logic program_store_control_hit;
    logic [2:0] bit_idx;
    logic [7:0] bit_byte;
    logic prog_in_flash;

    // reset release through two flops
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    cmm_store #(
        .FLASH_BYTES(FLASH_KB * 1024)
    ) u_store (
        .clk(I_SYS_CLK),
        .mem(mem.store)
    );

    assign mode = cmm_mode_t'(I_DATA_MODE);
    assign bank = I_PROGRAM_STATUS_WORD[4:3];
    // pointer lives in register 0 or 1 of the active bank
    assign mem.ptr_addr = {3'h0, bank, 2'h0, I_REG_IDX[0]};
    // bit address 0x00-0x7F lands in 0x20-0x2F, above it on an sfr byte
    assign bit_idx = I_DATA_ADDR[2:0];
    assign bit_byte = I_DATA_ADDR[7] ? {I_DATA_ADDR[7:3], 3'h0} :
                      BIT_AREA_BASE + {4'h0, I_DATA_ADDR[6:3]};

    // effective data address per addressing mode
    always_comb begin
        case (mode)
            CMM_REGISTER: eff_addr = {3'h0, bank, I_REG_IDX};
            CMM_INDIRECT: eff_addr = mem.ptr_data;
            CMM_BIT: eff_addr = bit_byte;
            default: eff_addr = I_DATA_ADDR;
        endcase
    end

    // direct and bit accesses above the lower half never touch upper ram
    assign to_sfr = (mode == CMM_DIRECT || mode == CMM_BIT) && (eff_addr > LOWER_TOP);
    assign power_mode_control_hit = to_sfr && mode == CMM_DIRECT && eff_addr == POWER_MODE_CONTROL_ADDR;
    assign program_store_control_hit = to_sfr && mode == CMM_DIRECT && eff_addr == PROGRAM_STORE_CONTROL_ADDR;

    // sfr bus, combinational handshake, the two local registers are kept off it
    assign O_SFR_REQ = I_DATA_REQ && to_sfr && !power_mode_control_hit && !program_store_control_hit;
    assign O_SFR_WE = I_DATA_WE;
    assign O_SFR_BIT = (mode == CMM_BIT);
    assign O_SFR_BIT_IDX = bit_idx;
    assign O_SFR_ADDR = eff_addr;
    assign O_SFR_WDATA = I_DATA_WDATA;

    // ram write, bit writes merge into the stored byte
    always_comb begin
        mem.ram_addr = eff_addr;
        mem.ram_we = I_DATA_REQ && I_DATA_WE && !to_sfr;
        mem.ram_wdata = I_DATA_WDATA;
        if (mode == CMM_BIT) begin
            mem.ram_wdata = mem.ram_rdata;
            mem.ram_wdata[bit_idx] = I_DATA_WDATA[0];
        end
    end

    // read data and ack, one cycle after the request
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_DATA_ACK <= 1'b0;
            O_DATA_RDATA <= 8'h00;
        end else begin
            O_DATA_ACK <= I_DATA_REQ;
            if (I_DATA_REQ && !I_DATA_WE) begin
                if (power_mode_control_hit) begin
                    O_DATA_RDATA <= 8'h00;
                end else if (program_store_control_hit) begin
                    O_DATA_RDATA <= {7'h00, store_we};
                end else if (to_sfr) begin
                    O_DATA_RDATA <= (mode == CMM_BIT) ? {7'h00, I_SFR_RDATA[bit_idx]} : I_SFR_RDATA;
                end else if (mode == CMM_BIT) begin
                    O_DATA_RDATA <= {7'h00, mem.ram_rdata[bit_idx]};
                end else begin
                    O_DATA_RDATA <= mem.ram_rdata;
                end
            end
        end
    end

    // program store enable; only bit 0 is held
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            store_we <= PROGRAM_STORE_CONTROL_RST[STORE_WE_BIT];
        end else if (I_DATA_REQ && I_DATA_WE && program_store_control_hit) begin
            store_we <= I_DATA_WDATA[STORE_WE_BIT];
        end
    end

    // program space is its own 64 kB map, selected by the core's instruction type
    assign prog_in_flash = I_PROG_ADDR <= USABLE_TOP;
    assign mem.prog_addr = I_PROG_ADDR;
    assign mem.prog_wdata = I_PROG_WDATA;
    // reserved and unimplemented space never takes a write
    assign mem.prog_we = I_PROG_REQ && I_PROG_WE && store_we && prog_in_flash;

    // program read, reserved or absent locations read as zero
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            O_PROG_ACK <= 1'b0;
            O_PROG_RESERVED <= 1'b0;
            O_PROG_RDATA <= 8'h00;
        end else begin
            O_PROG_ACK <= I_PROG_REQ;
            O_PROG_RESERVED <= I_PROG_REQ && !prog_in_flash;
            if (I_PROG_REQ && !I_PROG_WE) begin
                O_PROG_RDATA <= prog_in_flash ? mem.prog_rdata : 8'h00;
            end
        end
    end

    // power state; stop is left only through reset, so it has no exit arc
    always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            pwr_state <= PWR_RUN;
        end else begin
            case (pwr_state)
                PWR_RUN: begin
                    if (I_DATA_REQ && I_DATA_WE && power_mode_control_hit) begin
                        // stop wins when both bits are written together
                        if (I_DATA_WDATA[STOP_BIT]) begin
                            pwr_state <= I_INSTR_DONE ? PWR_STOP : PWR_STOP_PEND;
                        end else if (I_DATA_WDATA[IDLE_BIT]) begin
                            pwr_state <= I_INSTR_DONE ? PWR_IDLE : PWR_IDLE_PEND;
                        end
                    end
                end
                PWR_IDLE_PEND: begin
                    if (I_INSTR_DONE) begin
                        pwr_state <= PWR_IDLE;
                    end
                end
                PWR_IDLE: begin
                    if (I_IRQ_WAKE) begin
                        pwr_state <= PWR_RUN;
                    end
                end
                PWR_STOP_PEND: begin
                    if (I_INSTR_DONE) begin
                        pwr_state <= PWR_STOP;
                    end
                end
                PWR_STOP: begin
                    pwr_state <= PWR_STOP;
                end
                default: begin
                    pwr_state <= PWR_RUN;
                end
            endcase
        end
    end

    // halt holds the pc, so the core resumes at the next instruction
    assign O_IDLE = (pwr_state == PWR_IDLE);
    assign O_STOP = (pwr_state == PWR_STOP);
    assign O_CPU_HALT = O_IDLE || O_STOP;
    assign O_RESET_PC = RESET_VECTOR;
endmodule // cmm_mem_map

// ### hw/cmm_pkg.sv
package cmm_pkg;
    // direct-space addresses handled inside this block
    localparam logic [7:0] POWER_MODE_CONTROL_ADDR = 8'h87;
    localparam logic [7:0] PROGRAM_STORE_CONTROL_ADDR = 8'h8F;
    localparam logic [7:0] POWER_MODE_CONTROL_RST = 8'h00;
    localparam logic [7:0] PROGRAM_STORE_CONTROL_RST = 8'h00;
    localparam int IDLE_BIT = 0;
    localparam int STOP_BIT = 1;
    localparam int STORE_WE_BIT = 0;
    // data space layout
    localparam logic [7:0] LOWER_TOP = 8'h7F;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam int BANK_LSB = 3;
    // program space
    localparam int PROG_AW = 16;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] FLASH_8K_TOP = 16'h1FFF;
    localparam logic [15:0] FLASH_8K_USABLE_TOP = 16'h1DFF;
    localparam logic [15:0] FLASH_4K_TOP = 16'h0FFF;
    localparam logic [15:0] FLASH_2K_TOP = 16'h07FF;
    // addressing modes of a data access
    typedef enum logic [1:0] {
        CMM_DIRECT = 2'h0,
        CMM_INDIRECT = 2'h1,
        CMM_REGISTER = 2'h2,
        CMM_BIT = 2'h3
    } cmm_mode_t;
    // power state, one-hot
    typedef enum logic [4:0] {
        PWR_RUN = 5'h01,
        PWR_IDLE_PEND = 5'h02,
        PWR_IDLE = 5'h04,
        PWR_STOP_PEND = 5'h08,
        PWR_STOP = 5'h10
    } cmm_pwr_t;
endpackage

// ### hw/cmm_mem_if.sv
`timescale 1ns/1ps
interface cmm_mem_if;
    logic ram_we;
    logic [7:0] ram_addr;
    logic [7:0] ram_wdata;
    logic [7:0] ram_rdata;
    logic [7:0] ptr_addr;
    logic [7:0] ptr_data;
    logic prog_we;
    logic [15:0] prog_addr;
    logic [7:0] prog_wdata;
    logic [7:0] prog_rdata;
    modport ctrl (output ram_we, ram_addr, ram_wdata, ptr_addr, prog_we, prog_addr, prog_wdata,
                  input ram_rdata, ptr_data, prog_rdata);
    modport store (input ram_we, ram_addr, ram_wdata, ptr_addr, prog_we, prog_addr, prog_wdata,
                   output ram_rdata, ptr_data, prog_rdata);
endinterface

// ### hw/cmm_store.sv
`timescale 1ns/1ps
module cmm_store import cmm_pkg::*; #(
    parameter int FLASH_BYTES = 8192
) (
    input wire logic clk,
    cmm_mem_if.store mem
);
    // one 256-byte array covers lower and upper halves; sfrs live elsewhere
    logic [7:0] ram [0:255];
    logic [7:0] flash [0:FLASH_BYTES-1];

    // ram write port, contents survive idle since nothing clears them
    always_ff @(posedge clk) begin
        if (mem.ram_we) begin
            ram[mem.ram_addr] <= mem.ram_wdata;
        end
    end

    // program store write, gated upstream
    always_ff @(posedge clk) begin
        if (mem.prog_we) begin
            flash[mem.prog_addr[$clog2(FLASH_BYTES)-1:0]] <= mem.prog_wdata;
        end
    end

    // asynchronous reads so pointer fetch and access fit one cycle
    assign mem.ram_rdata = ram[mem.ram_addr];
    assign mem.ptr_data = ram[mem.ptr_addr];
    assign mem.prog_rdata = flash[mem.prog_addr[$clog2(FLASH_BYTES)-1:0]];
endmodule // cmm_store

// ### verification/cmm_mem_map_chk.sv
`timescale 1ns/1ps
module cmm_mem_map_chk import cmm_pkg::*; #(
    parameter int FLASH_KB = 8
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic I_DATA_REQ,
    input wire logic I_DATA_WE,
    input wire logic [1:0] I_DATA_MODE,
    input wire logic [7:0] I_DATA_ADDR,
    input wire logic [7:0] I_DATA_WDATA,
    input wire logic I_PROG_REQ,
    input wire logic [15:0] I_PROG_ADDR,
    input wire logic I_INSTR_DONE,
    input wire logic I_IRQ_WAKE,
    input logic O_DATA_ACK,
    input logic [7:0] O_DATA_RDATA,
    input logic O_SFR_REQ,
    input wire logic O_SFR_WE,
    input wire logic O_SFR_BIT,
    input wire logic [2:0] O_SFR_BIT_IDX,
    input wire logic [7:0] O_SFR_ADDR,
    input wire logic [7:0] O_SFR_WDATA,
    input logic O_PROG_ACK,
    input logic O_PROG_RESERVED,
    input logic O_IDLE,
    input logic O_STOP,
    input logic O_CPU_HALT
);
    localparam logic [15:0] TOP = (FLASH_KB == 8) ? FLASH_8K_USABLE_TOP :
        (FLASH_KB == 4) ? FLASH_4K_TOP : FLASH_2K_TOP;
    // power writes only count from run, so pending states are excluded
    logic dir_hi;
    logic pwr_wr;
    logic pwr_pend;
    // a mode write still waiting for its instruction to finish; later writes are ignored
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pwr_pend <= 1'b0;
        end else if (I_INSTR_DONE) begin
            pwr_pend <= 1'b0;
        end else if (I_DATA_REQ && I_DATA_WE && I_DATA_MODE == CMM_DIRECT
            && I_DATA_ADDR == POWER_MODE_CONTROL_ADDR && !O_IDLE && !O_STOP
            && (I_DATA_WDATA[STOP_BIT] || I_DATA_WDATA[IDLE_BIT])) begin
            pwr_pend <= 1'b1;
        end
    end
    assign dir_hi = I_DATA_REQ && I_DATA_MODE == CMM_DIRECT && I_DATA_ADDR > LOWER_TOP;
    assign pwr_wr = I_DATA_REQ && I_DATA_WE && I_DATA_MODE == CMM_DIRECT && I_INSTR_DONE
        && I_DATA_ADDR == POWER_MODE_CONTROL_ADDR && !O_IDLE && !O_STOP && !pwr_pend;
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);
    data_ack_a: assert property (I_DATA_REQ |=> O_DATA_ACK)
        else $error("data ack missing");
    ack_cause_a: assert property (O_DATA_ACK |-> $past(I_DATA_REQ))
        else $error("data ack without request");
    sfr_route_a: assert property (dir_hi && I_DATA_ADDR != POWER_MODE_CONTROL_ADDR
        && I_DATA_ADDR != PROGRAM_STORE_CONTROL_ADDR |-> O_SFR_REQ) else $error("sfr not hit");
    ram_route_a: assert property (O_SFR_REQ |-> I_DATA_REQ && I_DATA_ADDR > LOWER_TOP
        && I_DATA_MODE != CMM_INDIRECT && I_DATA_MODE != CMM_REGISTER)
        else $error("sfr hit by ram access");
    sfr_fields_a: assert property (O_SFR_REQ && I_DATA_MODE == CMM_DIRECT
        |-> O_SFR_ADDR == I_DATA_ADDR && O_SFR_WE == I_DATA_WE
        && O_SFR_WDATA == I_DATA_WDATA && !O_SFR_BIT) else $error("sfr qualifiers wrong");
    sfr_bit_a: assert property (O_SFR_REQ && I_DATA_MODE == CMM_BIT
        |-> O_SFR_BIT && O_SFR_ADDR == {I_DATA_ADDR[7:3], 3'h0}
        && O_SFR_BIT_IDX == I_DATA_ADDR[2:0]) else $error("sfr bit address wrong");
    pwr_zero_a: assert property (I_DATA_REQ && !I_DATA_WE && I_DATA_MODE == CMM_DIRECT
        && I_DATA_ADDR == POWER_MODE_CONTROL_ADDR |=> O_DATA_RDATA == 8'h00)
        else $error("power control not zero");
    prog_ack_a: assert property (I_PROG_REQ |=> O_PROG_ACK)
        else $error("program ack missing");
    reserved_a: assert property (I_PROG_REQ |=> O_PROG_RESERVED == ($past(I_PROG_ADDR) > TOP))
        else $error("reserved flag wrong");
    idle_entry_a: assert property (pwr_wr && I_DATA_WDATA[1:0] == 2'h1
        |=> O_IDLE && O_CPU_HALT && !O_STOP) else $error("idle not entered");
    stop_entry_a: assert property (pwr_wr && I_DATA_WDATA[STOP_BIT]
        |=> O_STOP && O_CPU_HALT && !O_IDLE) else $error("stop not entered");
    stop_hold_a: assert property (O_STOP |=> O_STOP && O_CPU_HALT)
        else $error("stop left without reset");
    idle_wake_a: assert property (O_IDLE && I_IRQ_WAKE |=> !O_IDLE && !O_CPU_HALT)
        else $error("idle not left on wake");
    idle_c: cover property (pwr_wr && I_DATA_WDATA == 8'h01);
    stop_c: cover property (pwr_wr && I_DATA_WDATA[STOP_BIT]);
    sfr_c: cover property (O_SFR_REQ);
    sfr_bit_c: cover property (O_SFR_REQ && O_SFR_BIT);
endmodule // cmm_mem_map_chk

bind cmm_mem_map cmm_mem_map_chk #(.FLASH_KB(FLASH_KB)) cmm_mem_map_chk_inst (
    .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_DATA_REQ(I_DATA_REQ), .I_DATA_WE(I_DATA_WE),
    .I_DATA_MODE(I_DATA_MODE), .I_DATA_ADDR(I_DATA_ADDR), .I_DATA_WDATA(I_DATA_WDATA),
    .I_PROG_REQ(I_PROG_REQ), .I_PROG_ADDR(I_PROG_ADDR), .I_INSTR_DONE(I_INSTR_DONE),
    .I_IRQ_WAKE(I_IRQ_WAKE), .O_DATA_ACK(O_DATA_ACK), .O_DATA_RDATA(O_DATA_RDATA),
    .O_SFR_REQ(O_SFR_REQ), .O_SFR_WE(O_SFR_WE), .O_SFR_BIT(O_SFR_BIT),
    .O_SFR_BIT_IDX(O_SFR_BIT_IDX), .O_SFR_ADDR(O_SFR_ADDR), .O_SFR_WDATA(O_SFR_WDATA),
    .O_PROG_ACK(O_PROG_ACK), .O_PROG_RESERVED(O_PROG_RESERVED),
    .O_IDLE(O_IDLE), .O_STOP(O_STOP), .O_CPU_HALT(O_CPU_HALT));

// ### verification/tb.sv
`timescale 1ns/1ps
module tb import cmm_pkg::*;;
    logic clk = 1'h0, rst_n = 1'h0, dreq = 1'h0, dwe = 1'h0, preq = 1'h0, pwe = 1'h0;
    logic done = 1'h0, wake = 1'h0, ack, pack, pres, halt, idle, stop;
    logic [1:0] dmode = 2'h0;
    logic [2:0] ridx = 3'h0;
    logic [7:0] daddr = 8'h00, wdata = 8'h00, program_status_word = 8'h00, sfr_rd = 8'h3C, pwd = 8'h00;
    logic [7:0] rdata, prdata;
    logic [15:0] paddr = 16'h0000, rpc;
    int n_errors = 0, compares = 0;
    // free-running clock
    always #2.5 clk = ~clk;
    cmm_mem_map #(.FLASH_KB(8)) cmm_mem_map_inst (.I_SYS_CLK(clk), .I_RST_N(rst_n),
        .I_DATA_REQ(dreq), .I_DATA_WE(dwe), .I_DATA_MODE(dmode), .I_DATA_ADDR(daddr),
        .I_REG_IDX(ridx), .I_DATA_WDATA(wdata), .I_PROGRAM_STATUS_WORD(program_status_word),
        .O_DATA_ACK(ack), .O_DATA_RDATA(rdata), .O_SFR_REQ(), .O_SFR_WE(), .O_SFR_BIT(),
        .O_SFR_BIT_IDX(), .O_SFR_ADDR(), .O_SFR_WDATA(), .I_SFR_RDATA(sfr_rd),
        .I_PROG_REQ(preq), .I_PROG_WE(pwe), .I_PROG_ADDR(paddr), .I_PROG_WDATA(pwd),
        .O_PROG_ACK(pack), .O_PROG_RESERVED(pres), .O_PROG_RDATA(prdata),
        .I_INSTR_DONE(done), .I_IRQ_WAKE(wake), .O_CPU_HALT(halt), .O_IDLE(idle),
        .O_STOP(stop), .O_RESET_PC(rpc));
    // compare, widened so x in any bit never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // reset held 16 cycles, then three edges for the release synchroniser
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // one data access; the address byte also carries the register index
    task automatic dacc(input logic w, input logic [1:0] m, input logic [7:0] a,
            input logic [7:0] d);
        @(posedge clk);
        dreq <= 1'h1;
        dwe <= w;
        dmode <= m;
        daddr <= a;
        ridx <= a[2:0];
        wdata <= d;
        @(posedge clk);
        dreq <= 1'h0;
        #1;
        chk(ack, 1'h1);
    endtask
    task automatic pacc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        preq <= 1'h1;
        pwe <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        preq <= 1'h0;
        #1;
        chk(pack, 1'h1);
    endtask
    // hang guard: far above the real run length
    initial begin
        #100000;
        n_errors++;
        end_sim();
    end
    // main sequence
    initial begin
        do_reset();
        chk({idle, stop, halt}, 3'h0);
        chk(rpc, 16'h0000);
        dacc(1'h1, CMM_DIRECT, POWER_MODE_CONTROL_ADDR, 8'hFC);
        dacc(1'h0, CMM_DIRECT, POWER_MODE_CONTROL_ADDR, 8'h00);
        chk(rdata, 8'h00);
        for (int b = 0; b < 4; b++) begin
            @(posedge clk);
            program_status_word <= 8'(b << 3);
            dacc(1'h1, CMM_REGISTER, 8'h07, 8'(8'h50 + b));
        end
        for (int b = 0; b < 4; b++) begin
            dacc(1'h0, CMM_DIRECT, 8'(b * 8 + 7), 8'h00);
            chk(rdata, 16'(8'h50 + b));
        end
        // bank 2 pointers: one to lower ram, one to the upper half
        @(posedge clk);
        program_status_word <= 8'h10;
        dacc(1'h1, CMM_DIRECT, 8'h10, 8'h30);
        dacc(1'h1, CMM_DIRECT, 8'h11, 8'hA0);
        dacc(1'h1, CMM_INDIRECT, 8'h00, 8'h66);
        dacc(1'h1, CMM_INDIRECT, 8'h01, 8'h77);
        dacc(1'h0, CMM_DIRECT, 8'h30, 8'h00);
        chk(rdata, 8'h66);
        dacc(1'h0, CMM_DIRECT, 8'hA0, 8'h00);
        chk(rdata, 8'h3C);
        // an sfr write at 0xA0 must leave the upper ram byte alone
        dacc(1'h1, CMM_DIRECT, 8'hA0, 8'h5A);
        dacc(1'h0, CMM_INDIRECT, 8'h01, 8'h00);
        chk(rdata, 8'h77);
        dacc(1'h1, CMM_DIRECT, 8'h22, 8'h00);
        dacc(1'h1, CMM_BIT, 8'h13, 8'h01);
        dacc(1'h0, CMM_DIRECT, 8'h22, 8'h00);
        chk(rdata, 8'h08);
        dacc(1'h0, CMM_BIT, 8'h13, 8'h00);
        chk(rdata[0], 1'h1);
        // bit 0xA3 is bit 3 of the sfr byte at 0xA0
        dacc(1'h0, CMM_BIT, 8'hA3, 8'h00);
        chk(rdata, 8'h01);
        // program store: enabled write lands, disabled write is dropped
        dacc(1'h1, CMM_DIRECT, PROGRAM_STORE_CONTROL_ADDR, 8'h01);
        dacc(1'h0, CMM_DIRECT, PROGRAM_STORE_CONTROL_ADDR, 8'h00);
        chk(rdata, 8'h01);
        pacc(1'h1, 16'h1DFF, 8'h5A);
        dacc(1'h1, CMM_DIRECT, PROGRAM_STORE_CONTROL_ADDR, 8'h00);
        pacc(1'h1, 16'h1DFF, 8'hA5);
        pacc(1'h0, 16'h1DFF, 8'h00);
        chk({pres, prdata}, 9'h05A);
        pacc(1'h0, 16'h1E00, 8'h00);
        chk({pres, prdata}, 9'h100);
        pacc(1'h0, 16'hFFFF, 8'h00);
        chk({pres, prdata}, 9'h100);
        @(posedge clk);
        done <= 1'h1;
        dacc(1'h1, CMM_DIRECT, POWER_MODE_CONTROL_ADDR, 8'h01);
        chk({idle, halt, stop}, 3'h6);
        @(posedge clk);
        done <= 1'h0;
        repeat (3) @(posedge clk);
        wake <= 1'h1;
        @(posedge clk);
        wake <= 1'h0;
        #1;
        chk({idle, halt}, 2'h0);
        dacc(1'h0, CMM_DIRECT, 8'h30, 8'h00);
        chk(rdata, 8'h66);
        // both bits set: stop has priority and only reset ends it
        @(posedge clk);
        done <= 1'h1;
        dacc(1'h1, CMM_DIRECT, POWER_MODE_CONTROL_ADDR, 8'h03);
        chk({idle, halt, stop}, 3'h3);
        @(posedge clk);
        done <= 1'h0;
        wake <= 1'h1;
        repeat (3) @(posedge clk);
        wake <= 1'h0;
        #1;
        chk(stop, 1'h1);
        do_reset();
        chk({stop, halt, rpc}, 18'h00000);
        end_sim();
    end
endmodule // tb
